// ===== rtl/instr_exec_codes_26_to_56.sv
/*
  Execution of function codes 26..56 of an 18-bit one's-complement machine,
  with an AHB-Lite register slave for loading and reading the machine state.
  Assumes one core storage port answering a read on the cycle after mem_req,
  on the same clock, and zero-wait single-word bus transfers.
*/
// Our own choices: the AHB-Lite slave port and the placing of the registers.
// How it works
// [RULE1] divide 36-bit A by (y); quotient to lower half, remainder to upper
// [RULE2] dividend equals quotient times divisor plus remainder; remainder takes dividend sign
// [RULE3] overflow stays set until skip-on-overflow or skip-on-no-overflow executes
// [RULE4] indexed divide uses y+B, otherwise same, fourteen microseconds
// [RULE5] program return jump stores P+1 at (y) low bits, jumps there plus one
// [RULE6] from entrance register the return jump stores P itself
// [RULE7] indexed return jump takes its save address from (y+B)
// [RULE8] index load copies all 18 bits of (y) or (y+B) into B
// [RULE9] direct jump sets P to y, indexed form to y+B, two microseconds
// [RULE10] indexed address uses full 18-bit one's-complement B, may cross banks
// [RULE11] constant load clears B then loads sign-extended 12-bit field
// [RULE12] constant modify adds sign-extended field to B in one's complement
// [RULE13] store zero writes an all-zero word to y or y+B
// [RULE14] index store writes B to y or y+B
// [RULE15] accumulator half stores write that half, source unchanged
// [RULE16] bitwise or of lower accumulator with (y)
// [RULE17] bitwise and of lower accumulator with (y)
// [RULE18] bitwise xor of lower accumulator with (y)
// [RULE19] indirect jump with enable drops lockout, P gets (y) bits 15..0
// [RULE20] plain indirect jump sets P from (y), lockout untouched
// [RULE21] index compare skip: equal skips, else B plus one and no skip
// [RULE22] code 50 is dispatched to the format II group by subfield
// [RULE23] every instruction here clears the comparison designator
// [RULE24] divide overflow when quotient does not fit; one's-complement arithmetic
// [RULE25] durations are whole base memory cycles of two microseconds
`include "exec_map.svh"
module instr_exec_codes_26_to_56 (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic mem_req,
  output logic mem_we,
  output exec_pkg::word_t mem_addr,
  output exec_pkg::word_t mem_wdata,
  input exec_pkg::word_t mem_rdata,
  output logic fmt2_pulse,
  output logic [5:0] fmt2_sub,
  output logic busy,
  output logic done,
  output logic lockout
);
  import exec_pkg::*;

  function automatic word_t oc_add(word_t a, word_t b);
    logic [18:0] s;
    s = {1'b0, a} + {1'b0, b};
    // end-around carry
    return s[17:0] + {17'h00000, s[18]};
  endfunction

  function automatic word_t sx12(logic [11:0] u);
    return {{6{u[11]}}, u};
  endfunction

  exec_state_t state_reg;
  word_t ir_reg, p_reg, acc_lo_reg, acc_hi_reg, b_reg;
  logic entr_reg, ovf_reg, cmp_reg, lock_reg, illegal_reg;
  logic [8:0] tick_reg, target_reg;
  logic wr_pend_reg, done_reg, fmt2_pulse_reg;
  logic [7:0] wr_addr_reg, rd_addr_reg;
  logic [5:0] fmt2_sub_reg;
  logic mem_req_reg, mem_we_reg;
  word_t mem_addr_reg, mem_wdata_reg;

  div_if dv ();
  ones_divider u_div (
    .clk_sys(clk_sys),
    .srst(srst),
    .dv(dv)
  );

  // bus slave: zero wait, always OKAY
  logic acc, idle, w_instr, w_prog, w_lower, w_upper, w_index, w_status;
  assign acc = hsel & htrans[1] & hready;
  assign idle = (state_reg == S_IDLE);
  assign w_instr = wr_pend_reg && wr_addr_reg == `OFF_INSTR;
  assign w_prog = wr_pend_reg && wr_addr_reg == `OFF_PROG && idle;
  assign w_lower = wr_pend_reg && wr_addr_reg == `OFF_LOWER && idle;
  assign w_upper = wr_pend_reg && wr_addr_reg == `OFF_UPPER && idle;
  assign w_index = wr_pend_reg && wr_addr_reg == `OFF_INDEX && idle;
  assign w_status = wr_pend_reg && wr_addr_reg == `OFF_STATUS;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_addr_reg <= 8'hff;
    end else begin
      wr_pend_reg <= acc & hwrite;
      if (acc) begin
        wr_addr_reg <= haddr[7:0];
        rd_addr_reg <= hwrite ? 8'hff : haddr[7:0];
      end
    end
  end

  always_comb begin
    case (rd_addr_reg)
      `OFF_INSTR: hrdata = {13'h0000, entr_reg, ir_reg};
      `OFF_PROG: hrdata = {14'h0000, p_reg};
      `OFF_LOWER: hrdata = {14'h0000, acc_lo_reg};
      `OFF_UPPER: hrdata = {14'h0000, acc_hi_reg};
      `OFF_INDEX: hrdata = {14'h0000, b_reg};
      `OFF_STATUS: hrdata = {27'h0000000, illegal_reg, lock_reg, cmp_reg, ovf_reg, ~idle};
      default: hrdata = 32'h00000000;
    endcase
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // decode
  logic [5:0] f, op;
  logic [11:0] u;
  word_t y, ea, st_data, tgt;
  logic idx, rd_op, wr_op, legal, in_dec, in_data, in_div, rd_eq, t_end;
  logic [2:0] n_base;
  assign f = ir_reg[`F_HI:`F_LO];
  assign u = ir_reg[`U_HI:0];
  assign y = {6'h00, u};
  assign op = (f < `OP_FORMAT_TWO) ? {f[5:1], 1'b0} : f;
  assign idx = f[0] && f < `OP_FORMAT_TWO && op != `OP_LOAD_INDEX_CONSTANT;
  assign ea = idx ? oc_add(y, b_reg) : y; // RULE10
  assign tgt = {2'b00, mem_rdata[15:0]};
  assign rd_eq = (mem_rdata == b_reg);
  assign in_dec = (state_reg == S_DEC);
  assign in_data = (state_reg == S_DATA);
  assign in_div = (state_reg == S_DIV);
  assign t_end = (tick_reg >= target_reg - 9'h001);

  always_comb begin
    rd_op = 1'b0;
    wr_op = 1'b0;
    legal = 1'b1;
    st_data = `RST_WORD;
    n_base = 3'(`N_MEMORY_OP);
    case (op)
      `OP_DIVIDE_DOUBLE: begin
        rd_op = 1'b1;
        n_base = 3'(`N_DIVIDE); // RULE4 RULE25
      end
      `OP_INDIRECT_RETURN_JUMP: begin
        rd_op = 1'b1;
        n_base = 3'(`N_RETURN_JUMP); // RULE25
      end
      `OP_LOAD_INDEX, `OP_BITWISE_OR, `OP_BITWISE_AND, `OP_BITWISE_XOR,
      `OP_INDIRECT_JUMP_ENABLE_IRQ, `OP_INDIRECT_JUMP, `OP_INDEX_COMPARE_SKIP: rd_op = 1'b1;
      `OP_DIRECT_JUMP, `OP_LOAD_INDEX_CONSTANT, `OP_FORMAT_TWO: n_base = 3'(`N_JUMP);
      `OP_STORE_ZERO: wr_op = 1'b1; // RULE13
      `OP_STORE_INDEX: begin
        wr_op = 1'b1;
        st_data = b_reg; // RULE14
      end
      `OP_STORE_LOWER_ACC: begin
        wr_op = 1'b1;
        st_data = acc_lo_reg; // RULE15
      end
      `OP_STORE_UPPER_ACC: begin
        wr_op = 1'b1;
        st_data = acc_hi_reg; // RULE15
      end
      default: begin
        legal = 1'b0;
        n_base = 3'(`N_JUMP);
      end
    endcase
  end

  // sequencer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= S_IDLE;
    end else begin
      case (state_reg)
        S_IDLE: if (w_instr) state_reg <= S_DEC;
        S_DEC: state_reg <= (rd_op | wr_op) ? S_REQ : S_HOLD;
        S_REQ: state_reg <= mem_we_reg ? S_HOLD : S_DATA;
        S_DATA: begin
          if (op == `OP_DIVIDE_DOUBLE) state_reg <= S_DIV;
          else if (op == `OP_INDIRECT_RETURN_JUMP) state_reg <= S_REQ;
          else state_reg <= S_HOLD;
        end
        S_DIV: if (dv.done) state_reg <= S_HOLD;
        S_HOLD: if (t_end) state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // duration: busy for n_base base cycles counted from decode
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tick_reg <= 9'h000;
      target_reg <= 9'h001;
      done_reg <= 1'b0;
    end else begin
      tick_reg <= idle ? 9'h000 : tick_reg + 9'h001;
      if (in_dec) target_reg <= 9'(n_base * `BASE_CYC); // RULE25
      done_reg <= (state_reg == S_HOLD) && t_end;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ir_reg <= `RST_WORD;
      entr_reg <= 1'b0;
    end else if (w_instr && idle) begin
      ir_reg <= hwdata[17:0];
      entr_reg <= hwdata[`ENTR_BIT];
    end
  end

  // storage port
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= `RST_WORD;
      mem_wdata_reg <= `RST_WORD;
    end else begin
      mem_req_reg <= 1'b0;
      if (in_dec && (rd_op || wr_op)) begin
        mem_req_reg <= 1'b1;
        mem_we_reg <= wr_op;
        mem_addr_reg <= ea; // RULE13 RULE14 RULE15
        mem_wdata_reg <= st_data;
      end else if (in_data && op == `OP_INDIRECT_RETURN_JUMP) begin
        mem_req_reg <= 1'b1;
        mem_we_reg <= 1'b1;
        mem_addr_reg <= tgt; // RULE7
        mem_wdata_reg <= entr_reg ? p_reg : p_reg + 18'h00001; // RULE5 RULE6
      end
    end
  end

  // program address
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      p_reg <= `RST_WORD;
    end else if (w_prog) begin
      p_reg <= hwdata[17:0];
    end else if (in_dec) begin
      if (op == `OP_DIRECT_JUMP) p_reg <= ea; // RULE9
      else if (op == `OP_LOAD_INDEX_CONSTANT || wr_op || !legal) p_reg <= p_reg + 18'h00001;
    end else if (in_data) begin
      case (op)
        `OP_INDIRECT_RETURN_JUMP: p_reg <= tgt + 18'h00001; // RULE5
        `OP_INDIRECT_JUMP_ENABLE_IRQ, `OP_INDIRECT_JUMP: p_reg <= tgt; // RULE19 RULE20
        `OP_INDEX_COMPARE_SKIP: p_reg <= p_reg + (rd_eq ? 18'h00002 : 18'h00001); // RULE21
        `OP_DIVIDE_DOUBLE: p_reg <= p_reg;
        default: p_reg <= p_reg + 18'h00001;
      endcase
    end else if (in_div && dv.done) begin
      p_reg <= p_reg + 18'h00001;
    end
  end

  // accumulator; overflow leaves A as it was
  assign dv.start = in_data && op == `OP_DIVIDE_DOUBLE; // RULE1 RULE4
  assign dv.dividend = {acc_hi_reg, acc_lo_reg};
  assign dv.divisor = mem_rdata;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      acc_lo_reg <= `RST_WORD;
      acc_hi_reg <= `RST_WORD;
    end else begin
      if (w_lower) acc_lo_reg <= hwdata[17:0];
      if (w_upper) acc_hi_reg <= hwdata[17:0];
      if (in_data) begin
        case (op)
          `OP_BITWISE_OR: acc_lo_reg <= acc_lo_reg | mem_rdata; // RULE16
          `OP_BITWISE_AND: acc_lo_reg <= acc_lo_reg & mem_rdata; // RULE17
          `OP_BITWISE_XOR: acc_lo_reg <= acc_lo_reg ^ mem_rdata; // RULE18
          default: acc_lo_reg <= acc_lo_reg;
        endcase
      end
      if (in_div && dv.done && !dv.ovf) begin
        acc_lo_reg <= dv.quot; // RULE1
        acc_hi_reg <= dv.rem; // RULE1 RULE2
      end
    end
  end

  // index register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      b_reg <= `RST_WORD;
    end else if (w_index) begin
      b_reg <= hwdata[17:0];
    end else if (in_dec && op == `OP_LOAD_INDEX_CONSTANT) begin
      b_reg <= f[0] ? oc_add(b_reg, sx12(u)) : sx12(u); // RULE11 RULE12
    end else if (in_data && op == `OP_LOAD_INDEX) begin
      b_reg <= mem_rdata; // RULE8
    end else if (in_data && op == `OP_INDEX_COMPARE_SKIP && !rd_eq) begin
      b_reg <= oc_add(b_reg, 18'h00001); // RULE21
    end
  end

  // designators
  logic ovf_set, ovf_clr;
  assign ovf_set = (in_div && dv.done && dv.ovf) || (w_status && hwdata[`ST_OVF]);
  assign ovf_clr = in_dec && op == `OP_FORMAT_TWO &&
    (u[`M_HI:`M_LO] == `SUB_SKIP_OVF || u[`M_HI:`M_LO] == `SUB_SKIP_NO_OVF);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ovf_reg <= 1'b0;
      cmp_reg <= 1'b0;
      lock_reg <= `RST_LOCK;
      illegal_reg <= 1'b0;
      fmt2_pulse_reg <= 1'b0;
      fmt2_sub_reg <= 6'h00;
    end else begin
      // a set in the same cycle as the clear wins
      ovf_reg <= ovf_set | (ovf_reg & ~ovf_clr); // RULE3 RULE24
      if (in_dec) cmp_reg <= 1'b0; // RULE23
      else if (w_status) cmp_reg <= hwdata[`ST_CMP];
      if (in_data && op == `OP_INDIRECT_JUMP_ENABLE_IRQ) lock_reg <= 1'b0; // RULE19
      else if (w_status) lock_reg <= hwdata[`ST_LOCK];
      if (in_dec) illegal_reg <= ~legal;
      fmt2_pulse_reg <= in_dec && op == `OP_FORMAT_TWO; // RULE22
      if (in_dec && op == `OP_FORMAT_TWO) fmt2_sub_reg <= u[`M_HI:`M_LO]; // RULE22
    end
  end

  assign mem_req = mem_req_reg;
  assign mem_we = mem_we_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign fmt2_pulse = fmt2_pulse_reg;
  assign fmt2_sub = fmt2_sub_reg;
  assign busy = ~idle;
  assign done = done_reg;
  assign lockout = lock_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  chk_cmp_cleared: assert property (in_dec |=> !cmp_reg) else $error("compare designator kept"); // RULE23
  chk_ovf_sticky: assert property ($fell(ovf_reg) |-> $past(ovf_clr)) else $error("overflow dropped"); // RULE3
  chk_jump_target: assert property (in_dec && op == `OP_DIRECT_JUMP |=> p_reg == $past(ea)) // RULE9
    else $error("jump target wrong");
  chk_zero_store: assert property (in_dec && op == `OP_STORE_ZERO |=> // RULE13
    mem_req && mem_we && mem_wdata == 18'h00000 && mem_addr == $past(ea)) else $error("zero store wrong");
  chk_fmt2_dispatch: assert property (in_dec && op == `OP_FORMAT_TWO |=> // RULE22
    fmt2_pulse && !mem_req ##1 !fmt2_pulse) else $error("format II not dispatched");
  chk_lockout_drop: assert property (in_data && op == `OP_INDIRECT_JUMP_ENABLE_IRQ |=> // RULE19
    !lockout && p_reg == {2'b00, $past(mem_rdata[15:0])}) else $error("lockout or target wrong");
  chk_skip_equal: assert property (in_data && op == `OP_INDEX_COMPARE_SKIP && rd_eq |=> // RULE21
    p_reg == $past(p_reg) + 18'h00002 && $stable(b_reg)) else $error("skip wrong");
  chk_div_sign: assert property (in_div && dv.done && !dv.ovf |=> // RULE2
    acc_hi_reg[17] == $past(acc_hi_reg[17])) else $error("remainder sign wrong");
  chk_entr_save: assert property (in_data && op == `OP_INDIRECT_RETURN_JUMP && entr_reg |=> // RULE6
    mem_we && mem_wdata == $past(p_reg)) else $error("entrance save wrong");
  chk_min_time: assert property ($rose(busy) |-> busy[*8]) else $error("instruction too short"); // RULE25
endmodule // instr_exec_codes_26_to_56

// ===== rtl/exec_map.svh
/*
  Offsets, field positions, reset values, opcodes and timing counts of the
  code 26..56 execution block. Assumes a 20 MHz system clock.
*/
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH

// bus register byte offsets
`define OFF_INSTR 8'h00
`define OFF_PROG 8'h04
`define OFF_LOWER 8'h08
`define OFF_UPPER 8'h0c
`define OFF_INDEX 8'h10
`define OFF_STATUS 8'h14

// instruction word fields
`define F_HI 17
`define F_LO 12
`define U_HI 11
`define M_HI 11
`define M_LO 6
`define ENTR_BIT 18

// status bits
`define ST_BUSY 0
`define ST_OVF 1
`define ST_CMP 2
`define ST_LOCK 3
`define ST_ILLEGAL 4

`define RST_WORD 18'h00000
`define RST_LOCK 1'b1

// base codes, even below 6'h28; odd neighbour below 6'h28 is the y+B form, except 6'h1f which adds the field to B
`define OP_DIVIDE_DOUBLE 6'h16
`define OP_INDIRECT_RETURN_JUMP 6'h18
`define OP_LOAD_INDEX 6'h1a
`define OP_DIRECT_JUMP 6'h1c
`define OP_LOAD_INDEX_CONSTANT 6'h1e
`define OP_STORE_ZERO 6'h20
`define OP_STORE_INDEX 6'h22
`define OP_STORE_LOWER_ACC 6'h24
`define OP_STORE_UPPER_ACC 6'h26
`define OP_FORMAT_TWO 6'h28
`define OP_BITWISE_OR 6'h29
`define OP_BITWISE_AND 6'h2a
`define OP_BITWISE_XOR 6'h2b
`define OP_INDIRECT_JUMP_ENABLE_IRQ 6'h2c
`define OP_INDIRECT_JUMP 6'h2d
`define OP_INDEX_COMPARE_SKIP 6'h2e
`define SUB_SKIP_OVF 6'h2a
`define SUB_SKIP_NO_OVF 6'h2b

// timing
`define CLK_PERIOD_NS 50
`define BASE_CYCLE_NS 2000
`define BASE_CYC ((`BASE_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_DIVIDE_NS 14000
`define T_RETURN_JUMP_NS 6000
`define T_MEMORY_OP_NS 4000
`define T_JUMP_NS 2000
`define N_DIVIDE (`T_DIVIDE_NS / `BASE_CYCLE_NS)
`define N_RETURN_JUMP (`T_RETURN_JUMP_NS / `BASE_CYCLE_NS)
`define N_MEMORY_OP (`T_MEMORY_OP_NS / `BASE_CYCLE_NS)
`define N_JUMP (`T_JUMP_NS / `BASE_CYCLE_NS)

`endif

// ===== rtl/exec_pkg.sv
/*
  Types shared by the execution block and its divider.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package exec_pkg;
  typedef logic [17:0] word_t;
  typedef logic [35:0] dword_t;
  typedef enum logic [2:0] {S_IDLE, S_DEC, S_REQ, S_DATA, S_DIV, S_HOLD} exec_state_t;
endpackage

// ===== rtl/div_if.sv
/*
  Request and result of one double-length divide.
  Assumes both ends run on clk_sys.
*/
interface div_if;
  import exec_pkg::*;
  logic start;
  dword_t dividend;
  word_t divisor;
  logic done;
  logic ovf;
  word_t quot;
  word_t rem;
  modport host (output start, dividend, divisor, input done, ovf, quot, rem);
  modport unit (input start, dividend, divisor, output done, ovf, quot, rem);
endinterface

// ===== rtl/ones_divider.sv
/*
  One's-complement 36 by 18 bit divider, sign-magnitude restoring, one
  quotient bit per cycle. Assumes start is a one-cycle pulse while idle.
*/
module ones_divider (
  input wire logic clk_sys,
  input wire logic srst,
  div_if.unit dv
);
  import exec_pkg::*;

  logic run_reg;
  logic [4:0] cnt_reg;
  logic [17:0] rem_reg;
  logic [16:0] low_reg;
  logic [16:0] q_reg;
  logic [16:0] dmag_reg;
  logic dneg_reg;
  logic qneg_reg;
  logic done_reg;
  logic ovf_reg;
  dword_t mag;
  logic [16:0] dmag;
  logic [17:0] trial;

  // magnitudes: one's-complement negation is plain inversion
  assign mag = dv.dividend[35] ? ~dv.dividend : dv.dividend;
  assign dmag = dv.divisor[17] ? ~dv.divisor[16:0] : dv.divisor[16:0];
  assign trial = {rem_reg[16:0], low_reg[16]};

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      run_reg <= 1'b0;
      done_reg <= 1'b0;
      ovf_reg <= 1'b0;
      cnt_reg <= 5'h00;
      rem_reg <= 18'h00000;
      low_reg <= 17'h00000;
      q_reg <= 17'h00000;
      dmag_reg <= 17'h00000;
      dneg_reg <= 1'b0;
      qneg_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (dv.start) begin
        dneg_reg <= dv.dividend[35];
        qneg_reg <= dv.dividend[35] ^ dv.divisor[17];
        dmag_reg <= dmag;
        rem_reg <= mag[34:17];
        low_reg <= mag[16:0];
        q_reg <= 17'h00000;
        cnt_reg <= 5'h00;
        // quotient must fit 17 magnitude bits; zero divisor never fits
        if (dmag == 17'h00000 || mag[34:17] >= {1'b0, dmag}) begin
          ovf_reg <= 1'b1; // RULE24
          done_reg <= 1'b1;
        end else begin
          ovf_reg <= 1'b0;
          run_reg <= 1'b1;
        end
      end else if (run_reg) begin
        if (trial >= {1'b0, dmag_reg}) begin
          rem_reg <= trial - {1'b0, dmag_reg};
          q_reg <= {q_reg[15:0], 1'b1};
        end else begin
          rem_reg <= trial;
          q_reg <= {q_reg[15:0], 1'b0};
        end
        low_reg <= {low_reg[15:0], 1'b0};
        cnt_reg <= cnt_reg + 5'h01;
        if (cnt_reg == 5'h10) begin
          run_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end

  // quotient signed by the sign rule, remainder always by the dividend
  assign dv.quot = qneg_reg ? ~{1'b0, q_reg} : {1'b0, q_reg}; // RULE2
  assign dv.rem = dneg_reg ? ~rem_reg : rem_reg; // RULE2
  assign dv.done = done_reg;
  assign dv.ovf = ovf_reg;
endmodule // ones_divider

// ===== testbench/core_store_model.sv
/*
  Behavioural core storage for the execution block bench.
  Assumes one requester on clk_sys; a read is answered the next cycle.
*/
module core_store_model (
  input wire logic clk_sys,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire exec_pkg::word_t mem_addr,
  input wire exec_pkg::word_t mem_wdata,
  output exec_pkg::word_t mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  word_t mem [0:262143];
  initial mem_rdata = 18'h0;
  // idle cycles flip the data so a sample one cycle late never matches by chance
  always @(posedge clk_sys) begin
    if (mem_req === 1'b1 && mem_we === 1'b1) mem[mem_addr] <= mem_wdata;
    if (mem_req === 1'b1 && mem_we !== 1'b1) mem_rdata <= mem[mem_addr];
    else mem_rdata <= ~mem_rdata;
  end
endmodule // core_store_model

// ===== testbench/testbench.sv
/*
  Self-checking bench for the code 26..56 execution block.
  Assumes the storage model answers reads on the cycle after mem_req.
*/
`include "exec_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic hready, hreadyout, hresp, mem_req, mem_we, fmt2_pulse, busy, done, lockout;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic [5:0] fmt2_sub;
  word_t mem_addr, mem_wdata, mem_rdata;
  int fails = 0;
  int total_checks = 0;
  int pulses = 0;
  assign hready = hreadyout;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (fmt2_pulse === 1'b1) pulses <= pulses + 1;

  instr_exec_codes_26_to_56 u_dut (.clk_sys(clk_sys), .srst(srst), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .fmt2_pulse(fmt2_pulse),
    .fmt2_sub(fmt2_sub), .busy(busy), .done(done), .lockout(lockout));
  core_store_model u_mem (.clk_sys(clk_sys), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // address and data phase each held until hready is seen high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hready !== 1'b1 && n < 20);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hready !== 1'b1 && n < 40);
    q = hrdata;
    chk("response", 0, hresp);
    if (n >= 40) begin
      chk("bus wait", 0, 1);
      complete_run();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask

  task automatic exec(input logic ent, input logic [5:0] f, input logic [11:0] u, input int cyc);
    int n = 0;
    bus(1'b1, `OFF_INSTR, {13'h0, ent, f, u});
    while (n < 400) begin
      @(posedge clk_sys);
      if (busy !== 1'b1) break;
      n++;
    end
    chk("busy cycles", cyc, n);
    chk("done pulse", 1, done);
    if (n >= 400) complete_run();
  endtask

  task automatic t_divide;
    word_t tv [4][5] = '{'{18'h0, 18'h5, 18'h4, 18'h1, 18'h1},
      '{18'h0, 18'h5, 18'h3fffb, 18'h3fffe, 18'h1},
      '{18'h3ffff, 18'h3fffa, 18'h4, 18'h3fffe, 18'h3fffe},
      '{18'h3ffff, 18'h3fffa, 18'h3fffb, 18'h1, 18'h3fffe}};
    bus(1'b1, `OFF_INDEX, 32'h8);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `OFF_UPPER, tv[i][0]);
      bus(1'b1, `OFF_LOWER, tv[i][1]);
      u_mem.mem[18'h108 + i] = tv[i][2];
      exec(1'b0, `OP_DIVIDE_DOUBLE + 6'(i % 2), 12'h108 + 12'(i) - 12'(8 * (i % 2)), 280);
      rd(`OFF_LOWER, tv[i][3], "quotient");
      rd(`OFF_UPPER, tv[i][4], "remainder");
    end
    $display("test divide finished");
  endtask

  task automatic t_flags;
    int p0;
    bus(1'b1, `OFF_LOWER, 32'h7);
    u_mem.mem[18'h120] = 18'h0;
    exec(1'b0, `OP_DIVIDE_DOUBLE, 12'h120, 280);
    rd(`OFF_LOWER, 32'h7, "lower after zero divide");
    bus(1'b0, `OFF_STATUS, 32'h0);
    chk("overflow set", 1, q[`ST_OVF]);
    bus(1'b1, `OFF_STATUS, 32'h4);
    exec(1'b0, `OP_BITWISE_OR, 12'h120, 80);
    bus(1'b0, `OFF_STATUS, 32'h0);
    chk("overflow kept", 1, q[`ST_OVF]);
    chk("compare cleared", 0, q[`ST_CMP]);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, `OFF_STATUS, 32'h2);
      bus(1'b1, `OFF_PROG, 32'h40);
      p0 = pulses;
      exec(1'b0, `OP_FORMAT_TWO, {`SUB_SKIP_OVF + 6'(i), 6'h0}, 40);
      chk("subfield", `SUB_SKIP_OVF + i, fmt2_sub);
      chk("dispatch pulses", p0 + 1, pulses);
      rd(`OFF_PROG, 32'h40, "prog after code 50");
      bus(1'b0, `OFF_STATUS, 32'h0);
      chk("overflow cleared", 0, q[`ST_OVF]);
    end
    exec(1'b0, 6'h3f, 12'h000, 40);
    bus(1'b0, `OFF_STATUS, 32'h0);
    chk("illegal flag", 1, q[`ST_ILLEGAL]);
    rd(`OFF_PROG, 32'h41, "prog after illegal");
    $display("test flags finished");
  endtask

  task automatic t_return_jump;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `OFF_PROG, 32'h2400);
      bus(1'b1, `OFF_INDEX, 32'h4);
      u_mem.mem[18'hd40] = 18'h31f10;
      u_mem.mem[18'h1f10] = 18'h0;
      exec(i == 1, `OP_INDIRECT_RETURN_JUMP + 6'(i / 2), i == 2 ? 12'hd3c : 12'hd40, 120);
      chk("saved return", i == 1 ? 32'h2400 : 32'h2401, u_mem.mem[18'h1f10]);
      rd(`OFF_PROG, 32'h1f11, "return target");
    end
    $display("test return jump finished");
  endtask

  task automatic t_index;
    u_mem.mem[18'h200] = 18'h2abcd;
    u_mem.mem[18'h201] = 18'h15432;
    exec(1'b0, `OP_LOAD_INDEX, 12'h200, 80);
    rd(`OFF_INDEX, 32'h2abcd, "index load");
    bus(1'b1, `OFF_INDEX, 32'h1);
    exec(1'b0, `OP_LOAD_INDEX + 6'h1, 12'h200, 80);
    rd(`OFF_INDEX, 32'h15432, "indexed index load");
    exec(1'b0, `OP_LOAD_INDEX_CONSTANT, 12'hfc1, 40);
    rd(`OFF_INDEX, 32'h3ffc1, "constant load");
    exec(1'b0, `OP_LOAD_INDEX_CONSTANT + 6'h1, 12'h002, 40);
    rd(`OFF_INDEX, 32'h3ffc3, "constant increment");
    exec(1'b0, `OP_LOAD_INDEX_CONSTANT + 6'h1, 12'hffe, 40);
    rd(`OFF_INDEX, 32'h3ffc2, "constant decrement");
    $display("test index finished");
  endtask

  task automatic t_jump;
    word_t bv [3] = '{18'h0, 18'h1000, 18'h3fffe};
    word_t pv [3] = '{18'h770, 18'h1770, 18'h76f};
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `OFF_INDEX, bv[i]);
      exec(1'b0, `OP_DIRECT_JUMP + 6'(i > 0), 12'h770, 40);
      rd(`OFF_PROG, pv[i], "jump target");
    end
    $display("test jump finished");
  endtask

  task automatic t_store;
    logic [5:0] op [4] = '{`OP_STORE_ZERO + 6'h1, `OP_STORE_INDEX, `OP_STORE_LOWER_ACC, `OP_STORE_UPPER_ACC + 6'h1};
    word_t ev [4] = '{18'h0, 18'h10, 18'h1234, 18'h2345};
    bus(1'b1, `OFF_LOWER, 32'h1234);
    bus(1'b1, `OFF_UPPER, 32'h2345);
    bus(1'b1, `OFF_INDEX, 32'h10);
    bus(1'b1, `OFF_PROG, 32'h0);
    for (int i = 0; i < 4; i++) begin
      u_mem.mem[18'h300 + i] = 18'h3ffff;
      u_mem.mem[18'h310 + i] = 18'h3ffff;
      exec(1'b0, op[i], 12'h300 + 12'(i), 80);
      chk("stored word", ev[i], u_mem.mem[18'h300 + i + 16 * op[i][0]]);
    end
    rd(`OFF_LOWER, 32'h1234, "lower kept");
    rd(`OFF_UPPER, 32'h2345, "upper kept");
    rd(`OFF_PROG, 32'h4, "prog steps");
    $display("test store finished");
  endtask

  task automatic t_logic;
    word_t yv [3] = '{18'h3f, 18'h38e38, 18'h7007};
    word_t ev [3] = '{18'ha73f, 18'h8628, 18'hd729};
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `OFF_LOWER, 32'ha72e);
      u_mem.mem[18'h330 + i] = yv[i];
      exec(1'b0, `OP_BITWISE_OR + 6'(i), 12'h330 + 12'(i), 80);
      rd(`OFF_LOWER, ev[i], "bitwise result");
    end
    $display("test logic finished");
  endtask

  task automatic t_indirect;
    u_mem.mem[18'h400] = 18'h31234;
    u_mem.mem[18'h500] = 18'h5;
    u_mem.mem[18'h501] = 18'h7;
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, `OFF_STATUS, 32'h8);
      exec(1'b0, `OP_INDIRECT_JUMP - 6'(i), 12'h400, 80);
      rd(`OFF_PROG, 32'h1234, "indirect target");
      chk("lockout", i == 0, lockout);
      bus(1'b1, `OFF_INDEX, 32'h5);
      bus(1'b1, `OFF_PROG, 32'h10);
      exec(1'b0, `OP_INDEX_COMPARE_SKIP, 12'h500 + 12'(i), 80);
      rd(`OFF_PROG, i ? 32'h11 : 32'h12, "skip prog");
      rd(`OFF_INDEX, i ? 32'h6 : 32'h5, "skip index");
    end
    $display("test indirect and skip finished");
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rd(`OFF_STATUS, 32'h8, "status after reset");
    rd(8'h40, 32'h0, "unmapped read");
    t_divide();
    t_flags();
    t_return_jump();
    t_index();
    t_jump();
    t_store();
    t_logic();
    t_indirect();
    complete_run();
  end
endmodule // testbench
